// ===== core/plss_energy_det.sv
// Energy detector: IIR filter with hysteresis thresholds
`timescale 1ns/1ns
module plss_energy_det import plss_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Sample and thresholds
    input wire logic [7:0] energySample,
    input wire logic [7:0] thrHigh,
    input wire logic [7:0] thrLow,
    // Result
    output logic present
);
    typedef struct packed {
        logic [7:0] filt;
        logic pres;
    } plss_ed_t;
    plss_ed_t state_q, state_d;

    // Filter then compare with hysteresis
    always_comb begin
        state_d = state_q;
        state_d.filt = 8'(({2'h0, state_q.filt} * 10'h3 + {2'h0, energySample}) >> 2);
        if (state_q.filt >= thrHigh) begin
            state_d.pres = 1'b1;
        end else if (state_q.filt < thrLow) begin
            state_d.pres = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
    assign present = state_q.pres;
endmodule : plss_energy_det

// ===== core/plss_mirror.sv
// Port mirror mapping of the four MDI pairs
`timescale 1ns/1ns
module plss_mirror import plss_pkg::*; (
    // Control
    input wire logic enable,
    input wire plss_speed_t speed,
    // Pairs A..D, index 0 is A
    input wire logic [3:0] pairIn,
    output logic [3:0] pairOut
);
    // Pair mapping per speed
    always_comb begin
        pairOut = pairIn;
        if (enable) begin
            if (speed == SPD1000) begin
                pairOut = {pairIn[0], pairIn[1], pairIn[2], pairIn[3]};
            end else begin
                pairOut = {pairIn[0], pairIn[1], 2'b00};
            end
        end
    end
endmodule : plss_mirror

// ===== core/plss_pkg.sv
// Package: register map, fields, strap and timing constants for link supervision
// Behaviour
// - Default window: drop under 1/0.5 ms; the code uses it only with all criteria disabled, so linkDrop never rises
// - Fast link-down shortens window below 10 us; the code uses exactly 10 us (1000 cycles)
// - Enabled criterion in window drops link
// - Each criterion has its own enable
// - Energy-loss at 100M strap selectable
// - Fast link settings in config three
// - Downshift after N gigabit failures, default four
// - Enhanced: one failure, no C/D energy
// - Further fallback to 10M after 100M fails
// - Downshift enable by strap or register
// - 10/100 mirror: A to D, B to C
// - Gigabit mirror swaps all four pairs
// - Mirror enable by strap or config four
// - Interrupt sources via control and status
// - Four test modes set in config one
// - Test mode drives pattern and test clock
// - Straps latched at power-up or hard reset
// - Software reset reloads latched straps
// - Each strap pin yields two bits
// - Strap settings also settable by software
// - Energy detect uses thresholds with hysteresis
package plss_pkg;
    // Register addresses (5-bit management address space, except config four, which needs 6 bits)
    localparam logic [4:0] ADDR_CFG_ONE = 5'h09;
    localparam logic [4:0] ADDR_INT_EN = 5'h12;
    localparam logic [4:0] ADDR_INT_STAT = 5'h13;
    localparam logic [4:0] ADDR_CFG_THREE = 5'h1E;
    // Config four sits above 5 bits; keep 6-bit address
    localparam logic [5:0] ADDR_CFG_FOUR = 6'h31;
    localparam int ADDR_W = 6;

    // config_one fields
    localparam int CONFIG_ONE_TEST_LSB = 13;   // Test mode field [15:13]
    localparam int CONFIG_ONE_DS_EN = 8;       // Downshift enable
    localparam int CONFIG_ONE_DS_ENH = 9;      // Enhanced downshift
    localparam int CONFIG_ONE_DS_CNT_LSB = 10; // Attempt count [12:10]
    localparam logic [2:0] DS_CNT_RST = 3'h4;
    // config_three fields: fast link-down criterion enables
    localparam int CONFIG_THREE_FLD_LSB = 0;     // [4:0] sync,rxerr,mlt3,mse,energy
    localparam int CONFIG_THREE_FLD_ENERGY = 4;
    // config_four fields
    localparam int CONFIG_FOUR_MIRROR = 0;
    // Interrupt bits
    localparam int INT_LINK = 0;
    localparam int INT_SPEED = 1;
    localparam int INT_DOWNSHIFT = 2;
    localparam int INT_ENERGY = 3;
    localparam int INT_W = 4;

    // Timing at 100 MHz
    localparam int CLK_NS = 10;
    localparam int WIN100_NS = 1000000;
    localparam int WIN1000_NS = 500000;
    localparam int WINFAST_NS = 10000;
    localparam int WIN100_CYC = WIN100_NS / CLK_NS;
    localparam int WIN1000_CYC = WIN1000_NS / CLK_NS;
    localparam int WINFAST_CYC = WINFAST_NS / CLK_NS;
    localparam int WIN_W = 17;
    localparam int TCLK_DIV = 4;         // Test clock divide
    localparam logic [7:0] ENERGY_HI_RST = 8'h40;
    localparam logic [7:0] ENERGY_LO_RST = 8'h20;

    typedef enum logic [1:0] {SPD10, SPD100, SPD1000} plss_speed_t;

    // Two bits per strap pin
    typedef struct packed {
        logic [1:0] fldEnergy;  // bit0 used
        logic [1:0] speedOpt;   // bit0 used
        logic [1:0] mirror;     // bit0 used
    } plss_strap_t;

    typedef struct packed {
        logic descramblerLoss;
        logic rxError;
        logic mlt3Error;
        logic mseExceed;
        logic energyLoss;
    } plss_crit_t;

    // Four-level strap decoding: level 1..4 -> 00..11
    function automatic logic [1:0] plss_strap_bits(input logic [1:0] level);
        return level;
    endfunction : plss_strap_bits
endpackage : plss_pkg

// ===== core/plss_top.sv
// Link supervision, downshift, mirror, interrupt, test mode and strap latch
`timescale 1ns/1ns
module plss_top import plss_pkg::*; (
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic softReset,
    // Strap pins, 4-level decoded to two bits
    input wire logic [1:0] strapFldEnergy,
    input wire logic [1:0] strapSpeedOpt,
    input wire logic [1:0] strapMirror,
    // Management register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    output logic [15:0] regRdata,
    // Receive status
    input wire plss_crit_t rxCrit,
    input wire logic [7:0] energySample,
    input wire logic energyCD,
    input wire logic linkAttemptFail,
    input wire logic linkUp,
    // MDI pairs
    input wire logic [3:0] pairTx,
    output logic [3:0] mdiOut,
    // Status outputs
    output logic linkDrop,
    output plss_speed_t speed,
    output logic interruptOut,
    output logic testClkOut
);
    typedef struct packed {
        plss_strap_t straps;
        logic [15:0] cfgOne;
        logic [15:0] intEn;
        logic [INT_W-1:0] intStat;
        logic [15:0] cfgThree;
        logic [15:0] cfgFour;
        logic [15:0] rdata;
        logic [WIN_W-1:0] winCnt;
        logic critSeen;
        logic dropFlag;
        logic [2:0] failCnt;
        plss_speed_t spd;
        logic fail100;
        logic [1:0] tclkCnt;
        logic tclk;
        logic strapPending;
        logic loadPending;
        logic linkPrev;
    } plss_state_t;

    plss_state_t state_q, state_d;
    logic energyPresent;
    logic [4:0] critVec;
    logic [4:0] critEn;
    logic critHit;
    logic [WIN_W-1:0] winLen;
    logic downshiftEn;
    logic mirrorEn;
    logic [2:0] testMode;
    logic [3:0] patternOut;
    logic [INT_W-1:0] events;

    // Energy detector feeding the energy-loss criterion
    plss_energy_det uEnergy (
        .clk(clk),
        .rst(rst),
        .energySample(energySample),
        .thrHigh(ENERGY_HI_RST),
        .thrLow(ENERGY_LO_RST),
        .present(energyPresent)
    );

    // Field views of the configuration registers
    assign critEn = state_q.cfgThree[CONFIG_THREE_FLD_LSB +: 5];
    assign critVec = {!energyPresent | rxCrit.energyLoss, rxCrit.mseExceed,
                      rxCrit.mlt3Error, rxCrit.rxError, rxCrit.descramblerLoss};
    assign critHit = |(critVec & critEn);
    assign downshiftEn = state_q.cfgOne[CONFIG_ONE_DS_EN];
    assign mirrorEn = state_q.cfgFour[CONFIG_FOUR_MIRROR];
    assign testMode = state_q.cfgOne[CONFIG_ONE_TEST_LSB +: 3];

    // Window length by mode and speed
    always_comb begin
        if (|critEn) begin
            winLen = WIN_W'(WINFAST_CYC);
        end else if (state_q.spd == SPD1000) begin
            winLen = WIN_W'(WIN1000_CYC);
        end else begin
            winLen = WIN_W'(WIN100_CYC);
        end
    end

    // Test pattern replaces transmit data during test modes
    always_comb begin
        if (testMode != 3'h0 && testMode <= 3'h4) begin
            patternOut = {4{state_q.tclk}};
        end else begin
            patternOut = pairTx;
        end
    end

    plss_mirror uMirror (
        .enable(mirrorEn),
        .speed(state_q.spd),
        .pairIn(patternOut),
        .pairOut(mdiOut)
    );

    // Status-change events
    assign events[INT_LINK] = linkUp ^ state_q.linkPrev;
    assign events[INT_SPEED] = state_d.spd != state_q.spd;
    assign events[INT_DOWNSHIFT] = state_d.spd != state_q.spd && state_d.spd != SPD1000;
    assign events[INT_ENERGY] = state_d.dropFlag & !state_q.dropFlag;

    // Next-state logic
    always_comb begin
        state_d = state_q;
        state_d.linkPrev = linkUp;
        state_d.rdata = state_q.rdata;

        // Straps sampled at the first edge after hard reset, loaded at the second
        if (state_q.strapPending) begin
            state_d.strapPending = 1'b0;
            state_d.loadPending = 1'b1;
            state_d.straps.fldEnergy = plss_strap_bits(strapFldEnergy);
            state_d.straps.speedOpt = plss_strap_bits(strapSpeedOpt);
            state_d.straps.mirror = plss_strap_bits(strapMirror);
        end

        // Software reset reloads strap defaults, no resample
        if (softReset || state_q.loadPending) begin
            state_d.loadPending = 1'b0;
            state_d.cfgThree = '0;
            state_d.cfgThree[CONFIG_THREE_FLD_ENERGY] = state_q.straps.fldEnergy[0];
            state_d.cfgOne = '0;
            state_d.cfgOne[CONFIG_ONE_DS_CNT_LSB +: 3] = DS_CNT_RST;
            state_d.cfgOne[CONFIG_ONE_DS_EN] = state_q.straps.speedOpt[0];
            state_d.cfgFour = '0;
            state_d.cfgFour[CONFIG_FOUR_MIRROR] = state_q.straps.mirror[0];
            state_d.intEn = '0;
            state_d.intStat = '0;
            state_d.spd = SPD1000;
            state_d.failCnt = '0;
            state_d.fail100 = 1'b0;
        end else begin
            // Register writes override strap defaults
            if (regWrite) begin
                case (regAddr)
                    {1'b0, ADDR_CFG_ONE}: state_d.cfgOne = regWdata;
                    {1'b0, ADDR_INT_EN}: state_d.intEn = regWdata;
                    {1'b0, ADDR_CFG_THREE}: state_d.cfgThree = regWdata;
                    ADDR_CFG_FOUR: state_d.cfgFour = regWdata;
                    default: ;
                endcase
            end

            // Link-loss window: count, check criteria
            if (!linkUp) begin
                state_d.winCnt = '0;
                state_d.critSeen = 1'b0;
                state_d.dropFlag = 1'b0;
            end else if (state_q.winCnt >= winLen - 1'b1) begin
                state_d.winCnt = '0;
                state_d.dropFlag = state_q.critSeen | critHit;
                state_d.critSeen = 1'b0;
            end else begin
                state_d.winCnt = state_q.winCnt + 1'b1;
                state_d.critSeen = state_q.critSeen | critHit;
            end

            // Downshift on failed attempts
            if (linkUp) begin
                state_d.failCnt = '0;
                state_d.fail100 = 1'b0;
            end else if (linkAttemptFail && downshiftEn) begin
                if (state_q.spd == SPD1000) begin
                    if (state_q.cfgOne[CONFIG_ONE_DS_ENH] && !energyCD) begin
                        state_d.spd = SPD100;
                        state_d.failCnt = '0;
                    end else if (state_q.failCnt + 1'b1 >= state_q.cfgOne[CONFIG_ONE_DS_CNT_LSB +: 3]) begin
                        state_d.spd = SPD100;
                        state_d.failCnt = '0;
                    end else begin
                        state_d.failCnt = state_q.failCnt + 1'b1;
                    end
                end else if (state_q.spd == SPD100) begin
                    state_d.spd = SPD10;
                end
            end

            // Interrupt status: set wins over read clear
            if (regRead && regAddr == {1'b0, ADDR_INT_STAT}) begin
                state_d.intStat = events;
            end else begin
                state_d.intStat = state_q.intStat | events;
            end
        end

        // Read data register
        if (regRead) begin
            case (regAddr)
                {1'b0, ADDR_CFG_ONE}: state_d.rdata = state_q.cfgOne;
                {1'b0, ADDR_INT_EN}: state_d.rdata = state_q.intEn;
                {1'b0, ADDR_INT_STAT}: state_d.rdata = {12'h000, state_q.intStat};
                {1'b0, ADDR_CFG_THREE}: state_d.rdata = state_q.cfgThree;
                ADDR_CFG_FOUR: state_d.rdata = state_q.cfgFour;
                default: state_d.rdata = 16'h0000;
            endcase
        end

        // Test clock divider, synchronous to pattern
        if (state_q.tclkCnt == 2'(TCLK_DIV / 2 - 1)) begin
            state_d.tclkCnt = '0;
            state_d.tclk = !state_q.tclk;
        end else begin
            state_d.tclkCnt = state_q.tclkCnt + 1'b1;
        end
    end

    // State register; link edge detector starts at the idle-up level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= '0;
            state_q.strapPending <= 1'b1;
            state_q.linkPrev <= 1'b1;
            state_q.spd <= SPD1000;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs
    assign regRdata = state_q.rdata;
    assign linkDrop = state_q.dropFlag;
    assign speed = state_q.spd;
    assign interruptOut = |(state_q.intStat & state_q.intEn[INT_W-1:0]);
    assign testClkOut = (testMode != 3'h0) ? state_q.tclk : 1'b0;
endmodule : plss_top

// ===== tb/plss_link_partner.sv
// Link partner model: receive status seen across the cable
`timescale 1ns/1ns
module plss_link_partner import plss_pkg::*; (
    // Clock, reset, scenario
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] mode,
    // Status toward the device
    output plss_crit_t rxCrit,
    output logic [7:0] energySample,
    output logic energyCD,
    output logic linkAttemptFail,
    output logic linkUp
);
    logic [2:0] tick;
    // 0 good, 1 sync loss, 2 failing attempts, 3 two-pair fails, 4 link down
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tick <= 3'h0;
            rxCrit <= '0;
            energySample <= 8'h80;
            energyCD <= 1'b1;
            linkAttemptFail <= 1'b0;
            linkUp <= 1'b1;
        end else begin
            tick <= tick + 3'h1;
            rxCrit <= '{descramblerLoss: mode == 3'h1, default: 1'b0};
            energySample <= (mode == 3'h4) ? 8'h00 : 8'h80;
            energyCD <= mode != 3'h3;
            linkUp <= mode <= 3'h1;
            linkAttemptFail <= (mode == 3'h2 || mode == 3'h3) && tick == 3'h7;
        end
    end
endmodule : plss_link_partner

// ===== tb/plss_top_properties.sv
// Port checker for the link supervision block
`timescale 1ns/1ns
module plss_top_properties import plss_pkg::*; (
    // Clock and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic softReset,
    // Register port
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic [15:0] regRdata,
    // Link side
    input wire logic linkUp,
    input wire logic linkAttemptFail,
    input wire logic [3:0] pairTx,
    input wire logic [3:0] mdiOut,
    // Status outputs
    input wire logic linkDrop,
    input wire plss_speed_t speed,
    input wire logic interruptOut,
    input wire logic testClkOut
);
    logic testOn_q;
    logic [INT_W-1:0] irqEn_q;
    logic [2:0] quiet_q;
    logic mapped;
    assign mapped = regAddr inside {6'(ADDR_CFG_ONE), 6'(ADDR_INT_EN), 6'(ADDR_INT_STAT),
        6'(ADDR_CFG_THREE), ADDR_CFG_FOUR};
    // Shadows of test mode and irq enable, and cycles since the last status change
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            testOn_q <= 1'b0;
            irqEn_q <= '0;
            quiet_q <= '0;
        end else begin
            if (softReset) testOn_q <= 1'b0;
            else if (regWrite && regAddr == 6'(ADDR_CFG_ONE)) testOn_q <= |regWdata[15:13];
            if (!softReset && regWrite && regAddr == 6'(ADDR_INT_EN))
                irqEn_q <= regWdata[INT_W-1:0];
            if ($changed(linkUp) || $changed(linkDrop) || $changed(speed)) quiet_q <= '0;
            else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence tclkHigh; testClkOut [*2] ##1 !testClkOut; endsequence
    sequence statRead; regRead && regAddr == 6'(ADDR_INT_STAT) && quiet_q == 3'h7; endsequence
    chk_tclk_idle: assert property (!testOn_q && !$past(testOn_q) |-> !testClkOut)
        else $error("test clock runs outside test mode");
    chk_tclk_shape: assert property (disable iff (rst || !testOn_q)
        $rose(testClkOut) && $past(testOn_q) |-> tclkHigh)
        else $error("test clock high phase not two cycles");
    chk_irq_enable: assert property (interruptOut |-> irqEn_q != '0)
        else $error("interrupt raised with all sources masked");
    chk_irq_clear: assert property (statRead ##1 quiet_q == 3'h7 |-> !interruptOut)
        else $error("interrupt kept after status read");
    chk_rdata_hold: assert property (!$past(regRead) |-> $stable(regRdata))
        else $error("read data changed without a read");
    chk_unmapped_zero: assert property (regRead && !mapped |=> regRdata == '0)
        else $error("unmapped read not zero");
    chk_mirror_gig: assert property (speed == SPD1000 && !testOn_q && mdiOut != pairTx
        |-> mdiOut == {pairTx[0], pairTx[1], pairTx[2], pairTx[3]}) else $error("gig mirror");
    chk_speed_cause: assert property ($changed(speed) && speed != SPD1000
        |-> $past(linkAttemptFail) || $past(linkAttemptFail, 2)) else $error("speed fell");
endmodule : plss_top_properties
bind plss_top plss_top_properties u_plss_top_properties (.clk, .rst, .softReset, .regWrite,
    .regRead, .regAddr, .regWdata, .regRdata, .linkUp, .linkAttemptFail, .pairTx, .mdiOut,
    .linkDrop, .speed, .interruptOut, .testClkOut);

// ===== tb/test_plss_top.sv
// Self-checking bench for straps, mirror, interrupt, drop, downshift and test modes
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin errCount++; \
    $display("wrong value %s exp %h got %h", nm, ex, got); end end
`define WAITB(c, n) begin for (int i = 0; i < (n) && !(c); i++) @(posedge clk) #1; \
    if (!(c)) begin errCount++; $display("wrong value wait exp 1 got 0"); wrapUp(); end end
module test_plss_top import plss_pkg::*; ;
    logic clk, rst, softReset, regWrite, regRead, energyCD, linkAttemptFail, linkUp;
    logic linkDrop, interruptOut, testClkOut, prev;
    logic [1:0] strapFldEnergy, strapSpeedOpt, strapMirror;
    logic [ADDR_W-1:0] regAddr;
    logic [15:0] regWdata, regRdata, rd;
    logic [3:0] pairTx, mdiOut;
    logic [2:0] mode;
    logic [7:0] energySample;
    logic [4:0] cnt;
    plss_crit_t rxCrit;
    plss_speed_t speed;
    int errCount = 0;
    int samplesChecked = 0;
    plss_top u_plss_top (.clk(clk), .rst(rst), .softReset(softReset),
        .strapFldEnergy(strapFldEnergy), .strapSpeedOpt(strapSpeedOpt),
        .strapMirror(strapMirror), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
        .regWdata(regWdata), .regRdata(regRdata), .rxCrit(rxCrit), .energySample(energySample),
        .energyCD(energyCD), .linkAttemptFail(linkAttemptFail), .linkUp(linkUp),
        .pairTx(pairTx), .mdiOut(mdiOut), .linkDrop(linkDrop), .speed(speed),
        .interruptOut(interruptOut), .testClkOut(testClkOut));
    plss_link_partner u_plss_link_partner (.clk(clk), .rst(rst), .mode(mode), .rxCrit(rxCrit),
        .energySample(energySample), .energyCD(energyCD), .linkAttemptFail(linkAttemptFail),
        .linkUp(linkUp));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic wrapUp;
        $display("Comparisons %0d mismatches %0d", samplesChecked, errCount);
        if (errCount == 0 && samplesChecked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : wrapUp
    task automatic hardReset;
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : hardReset
    task automatic regWr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : regWr
    task automatic regRd(input logic [ADDR_W-1:0] a);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        rd = regRdata;
    endtask : regRd
    task automatic test_straps;
        regRd(6'h09);
        `CHK("cfg one", 16'h1100, rd)
        regRd(6'h31);
        `CHK("cfg four", 16'h0001, rd)
        regRd(6'h1E);
        `CHK("cfg three", 16'h0000, rd)
        regRd(6'h05);
        `CHK("unmapped", 16'h0000, rd)
        `CHK("mdi gig", 4'hA, mdiOut)
        $display("test_straps done");
    endtask : test_straps
    task automatic test_irq;
        regWr(6'h12, 16'h0001);
        regRd(6'h13);
        mode <= 3'h4;
        `WAITB(interruptOut, 20)
        regRd(6'h13);
        `CHK("status link", 16'h0001, rd & 16'h0001)
        `CHK("irq cleared", 1'b0, interruptOut)
        regWr(6'h12, 16'h0000);
        mode <= 3'h0;
        repeat (12) @(posedge clk);
        #1;
        `CHK("irq masked", 1'b0, interruptOut)
        regWr(6'h12, 16'h0001);
        #1;
        `CHK("irq pending", 1'b1, interruptOut)
        repeat (8) @(posedge clk);
        regRd(6'h13);
        `CHK("irq after read", 1'b0, interruptOut)
        $display("test_irq done");
    endtask : test_irq
    task automatic test_fast_drop;
        regWr(6'h1E, 16'h0002);
        mode <= 3'h1;
        repeat (2100) @(posedge clk);
        #1;
        `CHK("drop other crit", 1'b0, linkDrop)
        regWr(6'h1E, 16'h0001);
        `WAITB(linkDrop, 2100)
        regWr(6'h1E, 16'h0000);
        mode <= 3'h0;
        $display("test_fast_drop done");
    endtask : test_fast_drop
    task automatic test_test_mode;
        for (int m = 1; m <= 4; m++) begin
            regWr(6'h09, 16'h1100 | (16'(m) << 13));
            cnt = '0;
            repeat (4) @(posedge clk);
            #1;
            prev = testClkOut;
            repeat (16) begin
                @(posedge clk) #1;
                cnt += 5'(testClkOut && !prev);
                prev = testClkOut;
            end
            `CHK("test clock rises", 5'd4, cnt)
            regWr(6'h09, 16'h1100);
            repeat (4) @(posedge clk);
            #1;
            `CHK("test clock idle", 1'b0, testClkOut)
        end
        $display("test_test_mode done");
    endtask : test_test_mode
    task automatic test_downshift;
        mode <= 3'h2;
        for (int k = 1; k <= 4; k++) begin
            `WAITB(linkAttemptFail, 20)
            repeat (3) @(posedge clk);
            #1;
            `CHK("speed", (k < 4) ? SPD1000 : SPD100, speed)
        end
        `CHK("mdi slow", 4'h8, mdiOut)
        `WAITB(speed == SPD10, 200)
        `CHK("mdi ten", 4'h8, mdiOut)
        mode <= 3'h0;
        $display("test_downshift done");
    endtask : test_downshift
    task automatic test_resets;
        regWr(6'h31, 16'h0000);
        strapMirror <= 2'b00;
        strapFldEnergy <= 2'b01;
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        regRd(6'h31);
        `CHK("cfg four reload", 16'h0001, rd)
        hardReset();
        regRd(6'h31);
        `CHK("cfg four strap", 16'h0000, rd)
        regRd(6'h1E);
        `CHK("cfg three strap", 16'h0010, rd)
        regWr(6'h09, 16'h1300);
        mode <= 3'h3;
        `WAITB(linkAttemptFail, 20)
        repeat (3) @(posedge clk);
        #1;
        `CHK("enhanced speed", SPD100, speed)
        $display("test_resets done");
    endtask : test_resets
    initial begin
        rst = 1'b1;
        softReset = 1'b0;
        regWrite = 1'b0;
        regRead = 1'b0;
        regAddr = '0;
        regWdata = '0;
        pairTx = 4'h5;
        mode = 3'h0;
        strapFldEnergy = 2'b00;
        strapSpeedOpt = 2'b01;
        strapMirror = 2'b01;
        hardReset();
        test_straps();
        test_irq();
        test_fast_drop();
        test_test_mode();
        test_downshift();
        test_resets();
        wrapUp();
    end
endmodule : test_plss_top
